/* File: gate_driver_aux_config_regs.sv */
// Auxiliary gate drive configuration and phase log register bank
`default_nettype none
`include "gdu_aux_defines.svh"

// Behaviour
// - Divider codes 11011..11111 give bus clock divided by 384,400,512,768,800.
// - Lower divider codes give 4, then 6..14 in pairs, then 16..256.
// - Boost current limit writes ignored while write lock is set.
// - Phase select is buffered; applied at reload after load okay set.
// - Reading phase select returns the buffered value, not the active one.
// - Code 00 routes drain supply /12; 01..11 route source phases /6.
// - Phase select and sense offset writable and readable at any time.
// - Sense offset holds amp1 in bits 6:4, amp0 in bits 2:0.
// - Offset codes: 000,100 none; 001..011 positive; 101..111 negative millivolts.
// - Desat level: high side 6:4, low side 2:0, write only when unlocked.
// - High side threshold is drain supply minus 0.30V plus 0.15V per step.
// - Low side threshold is 0.30V plus 0.15V per step.
// - On desaturation error the phase status bits are copied to phase log.
// - Phase log ignores bus writes; only reset clears it.
module gate_driver_aux_config_regs
(
	input  wire logic                     clk_i,
	input  wire logic                     rst_n_i,
	input  wire gdu_aux_pkg::bus_req_t    bus_i,
	output logic                    [7:0] rdata_o,
	input  wire logic                     pwm_reload_i,
	input  wire logic                     desat_err_i,
	input  wire logic               [2:0] phase_status_i,
	output logic                    [7:0] boost_current_limit_o,
	output logic                    [1:0] boost_duty_o,
	output logic                          boost_clk_o,
	output gdu_aux_pkg::phase_sel_t       phase_sel_active_o,
	output logic                    [4:0] divide_ratio_o,
	output gdu_aux_pkg::field_pair_t      amp_offset_o,
	output gdu_aux_pkg::field_pair_t      desat_level_o,
	output logic                    [2:0] phase_log_o,
	output logic                          write_lock_o
);
	import gdu_aux_pkg::*;

	// Signed offset in millivolts for one three-bit code
	function automatic logic signed [4:0] offset_mv(input logic [2:0] code);
		begin
			case (code)
				3'h1: offset_mv = 5'sd5;
				3'h2: offset_mv = 5'sd10;
				3'h3: offset_mv = 5'sd15;
				3'h5: offset_mv = -5'sd15;
				3'h6: offset_mv = -5'sd10;
				3'h7: offset_mv = -5'sd5;
				default: offset_mv = 5'sd0;
			endcase
		end
	endfunction

	// threshold per code
	// Desat threshold step in units of 10 mV: 30 + 15 per code
	// High side subtracts this from the drain supply, low side uses it as is
	function automatic logic [7:0] desat_cv(input logic [2:0] code);
		begin
			desat_cv = 8'h1E + 8'({code, 4'h0} - {4'h0, code});
		end
	endfunction

	logic        we;
	logic        lock_q, lock_d;
	logic        loadok_q, loadok_d;
	logic [4:0]  div_q, div_d;
	logic [1:0]  duty_q, duty_d;
	logic [7:0]  bcl_q, bcl_d;
	logic [1:0]  psel_buf_q, psel_buf_d;
	phase_sel_t  psel_act_q, psel_act_d;
	field_pair_t cso_q, cso_d;
	field_pair_t dsl_q, dsl_d;
	logic [2:0]  phl_q, phl_d;
	logic [7:0]  rdata_q, rdata_d;
	logic [9:0]  factor;
	logic        bclk;
	logic        bclk_q;

	assign we = bus_i.wr;

	// Divider lookup and the boost clock it produces
	boost_div_decode u_dec
	(
		.code_i   (div_q),
		.factor_o (factor)
	);

	boost_clk_gen u_gen
	(
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.factor_i    (factor),
		.boost_clk_o (bclk)
	);

	// Next values of the configuration registers
	always_comb
	begin
		lock_d     = lock_q;
		loadok_d   = loadok_q;
		div_d      = div_q;
		duty_d     = duty_q;
		bcl_d      = bcl_q;
		psel_buf_d = psel_buf_q;
		psel_act_d = psel_act_q;
		cso_d      = cso_q;
		dsl_d      = dsl_q;
		phl_d      = phl_q;
		// apply buffer at reload after load okay, which then self clears
		if (pwm_reload_i && loadok_q)
		begin
			psel_act_d = phase_sel_t'(psel_buf_q);
			loadok_d   = 1'b0;
		end
		if (we)
		begin
			case (bus_i.addr)
				`OFF_LOCK_CTRL:
				begin
					// Lock is sticky until reset so a runaway write cannot undo it
					if (bus_i.wdata[`LOCK_BIT])
						lock_d = 1'b1;
					if (bus_i.wdata[`LOADOK_BIT])
						loadok_d = 1'b1;
				end
				`OFF_CLK_CTRL:
				begin
					if (!lock_q)
					begin
						div_d  = bus_i.wdata[`CLK_DIV_HI:`CLK_DIV_LO];
						duty_d = bus_i.wdata[`CLK_DUTY_HI:`CLK_DUTY_LO];
					end
				end
				`OFF_BOOST_LIMIT:
				begin
					if (!lock_q)
						bcl_d = bus_i.wdata;
				end
				`OFF_PHASE_SEL:
				begin
					psel_buf_d = bus_i.wdata[`PSEL_HI:`PSEL_LO];
				end
				`OFF_SENSE_OFFSET:
				begin
					cso_d.hi = bus_i.wdata[`HI_FIELD_HI:`HI_FIELD_LO];
					cso_d.lo = bus_i.wdata[`LO_FIELD_HI:`LO_FIELD_LO];
				end
				`OFF_DESAT_LEVEL:
				begin
					if (!lock_q)
					begin
						dsl_d.hi = bus_i.wdata[`HI_FIELD_HI:`HI_FIELD_LO];
						dsl_d.lo = bus_i.wdata[`LO_FIELD_HI:`LO_FIELD_LO];
					end
				end
				default:
				begin
					// phase log offset and unmapped writes ignored
					phl_d = phl_q;
				end
			endcase
		end
		// capture phase status on desat error
		if (desat_err_i)
			phl_d = phase_status_i;
	end

	// Read data, valid only in the cycle after the read strobe
	always_comb
	begin
		rdata_d = `RST_BYTE;
		if (bus_i.rd)
		begin
			case (bus_i.addr)
				`OFF_CLK_CTRL:     rdata_d = {1'b0, div_q, duty_q};
				`OFF_BOOST_LIMIT:  rdata_d = bcl_q;
				`OFF_PHASE_SEL:    rdata_d = {6'h00, psel_buf_q};
				`OFF_SENSE_OFFSET: rdata_d = {1'b0, cso_q.hi, 1'b0, cso_q.lo};
				`OFF_DESAT_LEVEL:  rdata_d = {1'b0, dsl_q.hi, 1'b0, dsl_q.lo};
				`OFF_PHASE_LOG:    rdata_d = {5'h00, phl_q};
				`OFF_LOCK_CTRL:    rdata_d = {6'h00, loadok_q, lock_q};
				default:           rdata_d = `RST_BYTE;
			endcase
		end
	end

	// Register stage
	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			lock_q     <= 1'b0;
			loadok_q   <= 1'b0;
			div_q      <= `RST_DIV;
			duty_q     <= `RST_DUTY;
			bcl_q      <= `RST_BYTE;
			psel_buf_q <= `RST_PSEL;
			psel_act_q <= PSEL_DRAIN;
			cso_q      <= '0;
			dsl_q      <= '0;
			phl_q      <= `RST_FIELD3;
			rdata_q    <= `RST_BYTE;
			bclk_q     <= 1'b0;
		end
		else
		begin
			lock_q     <= lock_d;
			loadok_q   <= loadok_d;
			div_q      <= div_d;
			duty_q     <= duty_d;
			bcl_q      <= bcl_d;
			psel_buf_q <= psel_buf_d;
			psel_act_q <= psel_act_d;
			cso_q      <= cso_d;
			dsl_q      <= dsl_d;
			phl_q      <= phl_d;
			rdata_q    <= rdata_d;
			bclk_q     <= bclk;
		end
	end

	// divide ratio of the routed voltage: drain /12, phases /6
	logic [4:0] ratio_q;
	logic [4:0] ratio_d;

	// Taken from the next active select so ratio and select switch on the same edge
	always_comb
	begin
		ratio_d = (psel_act_d == PSEL_DRAIN) ? `RATIO_DRAIN : `RATIO_PHASE;
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ratio_q <= `RATIO_DRAIN;
		else
			ratio_q <= ratio_d;
	end

	assign rdata_o               = rdata_q;
	assign boost_current_limit_o = bcl_q;
	assign boost_duty_o          = duty_q;
	assign boost_clk_o           = bclk_q;
	assign phase_sel_active_o    = psel_act_q;
	assign divide_ratio_o        = ratio_q;
	assign amp_offset_o          = cso_q;
	assign desat_level_o         = dsl_q;
	assign phase_log_o           = phl_q;
	assign write_lock_o          = lock_q;

	// Assertions
	// boost limit holds when locked
	a_bcl_locked_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(lock_q && we && bus_i.addr == `OFF_BOOST_LIMIT) |=> $stable(bcl_q))
		else $error("boost limit changed while locked");
	a_dsl_locked_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(lock_q && we && bus_i.addr == `OFF_DESAT_LEVEL) |=> $stable(dsl_q))
		else $error("desat level changed while locked");
	// active select changes only at reload with load okay
	a_psel_apply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!(pwm_reload_i && loadok_q) |=> $stable(phase_sel_active_o))
		else $error("active select changed without reload");
	a_psel_copy: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(pwm_reload_i && loadok_q) |=> phase_sel_active_o == $past(psel_buf_q))
		else $error("reload did not apply buffered select");
	// phase select written regardless of lock
	a_psel_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(we && bus_i.addr == `OFF_PHASE_SEL) |=>
		psel_buf_q == $past(bus_i.wdata[`PSEL_HI:`PSEL_LO]))
		else $error("phase select write lost");
	// sense offset write stores both fields
	a_cso_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(we && bus_i.addr == `OFF_SENSE_OFFSET) |=>
		cso_q.hi == $past(bus_i.wdata[`HI_FIELD_HI:`HI_FIELD_LO])
		&& cso_q.lo == $past(bus_i.wdata[`LO_FIELD_HI:`LO_FIELD_LO]))
		else $error("sense offset write lost");
	a_phl_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		desat_err_i |=> phase_log_o == $past(phase_status_i))
		else $error("phase log missed capture");
	a_phl_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		!desat_err_i |=> $stable(phase_log_o))
		else $error("phase log changed without error");
	a_psel_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		(bus_i.rd && bus_i.addr == `OFF_PHASE_SEL) |=> rdata_o == {6'h00, $past(psel_buf_q)})
		else $error("phase select readback wrong");
	a_ratio_map: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		divide_ratio_o == ((phase_sel_active_o == PSEL_DRAIN) ? `RATIO_DRAIN : `RATIO_PHASE))
		else $error("divide ratio mismatch");
endmodule
`default_nettype wire

/* File: gdu_aux_defines.svh */
// Register offsets, field positions and reset values of the auxiliary gate drive registers
`ifndef GDU_AUX_DEFINES_SVH
`define GDU_AUX_DEFINES_SVH

`define ADDR_W            4
`define OFF_CLK_CTRL      4'h0
`define OFF_BOOST_LIMIT   4'h1
`define OFF_PHASE_SEL     4'h2
`define OFF_SENSE_OFFSET  4'h3
`define OFF_DESAT_LEVEL   4'h4
`define OFF_PHASE_LOG     4'h5
`define OFF_LOCK_CTRL     4'h6
`define CLK_DIV_HI        6
`define CLK_DIV_LO        2
`define CLK_DUTY_HI       1
`define CLK_DUTY_LO       0
`define PSEL_HI           1
`define PSEL_LO           0
`define HI_FIELD_HI       6
`define HI_FIELD_LO       4
`define LO_FIELD_HI       2
`define LO_FIELD_LO       0
`define LOCK_BIT          0
`define LOADOK_BIT        1
`define RST_BYTE          8'h00
`define RST_PSEL          2'h0
`define RST_FIELD3        3'h0
`define RST_DIV           5'h00
`define RST_DUTY          2'h0
`define FIELD3_W          3
`define RATIO_DRAIN       5'h0C
`define RATIO_PHASE       5'h06

`endif

/* File: gdu_aux_pkg.sv */
// Types shared by the auxiliary gate drive register bank
`default_nettype none
package gdu_aux_pkg;
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	typedef struct packed {
		logic [2:0] hi;
		logic [2:0] lo;
	} field_pair_t;

	typedef enum logic [1:0] {
		PSEL_DRAIN,
		PSEL_PHASE0,
		PSEL_PHASE1,
		PSEL_PHASE2
	} phase_sel_t;
endpackage
`default_nettype wire

/* File: boost_div_decode.sv */
// Boost clock divider code to divide factor
`default_nettype none
`include "gdu_aux_defines.svh"
module boost_div_decode
(
	input  wire logic [4:0] code_i,
	output logic      [9:0] factor_o
);
	// Table from the five-bit code; small steps low, coarse steps high
	always_comb
	begin
		case (code_i)
			5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: factor_o = 10'h004;
			5'h06, 5'h07: factor_o = 10'h006;
			5'h08, 5'h09: factor_o = 10'h008;
			5'h0A, 5'h0B: factor_o = 10'h00A;
			5'h0C, 5'h0D: factor_o = 10'h00C;
			5'h0E, 5'h0F: factor_o = 10'h00E;
			5'h10: factor_o = 10'h010;
			5'h11: factor_o = 10'h018;
			5'h12: factor_o = 10'h020;
			5'h13: factor_o = 10'h030;
			5'h14: factor_o = 10'h040;
			5'h15: factor_o = 10'h060;
			5'h16: factor_o = 10'h064;
			5'h17: factor_o = 10'h080;
			5'h18: factor_o = 10'h0C0;
			5'h19: factor_o = 10'h0C8;
			5'h1A: factor_o = 10'h100;
			5'h1B: factor_o = 10'h180;
			5'h1C: factor_o = 10'h190;
			5'h1D: factor_o = 10'h200;
			5'h1E: factor_o = 10'h300;
			5'h1F: factor_o = 10'h320;
			default: factor_o = 10'h004;
		endcase
	end
endmodule
`default_nettype wire

/* File: boost_clk_gen.sv */
// Boost clock generator dividing the bus clock by a programmed factor
`default_nettype none
`include "gdu_aux_defines.svh"
module boost_clk_gen
(
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [9:0] factor_i,
	output logic            boost_clk_o
);
	logic [9:0] cnt_q;
	logic [9:0] cnt_d;
	logic       out_q;
	logic       out_d;

	// Counter wraps at factor-1; output high for the first half (50 percent duty)
	always_comb
	begin
		if (cnt_q >= factor_i - 10'h001)
			cnt_d = 10'h000;
		else
			cnt_d = cnt_q + 10'h001;
		out_d = (cnt_d < (factor_i >> 1));
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_q <= 10'h000;
			out_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign boost_clk_o = out_q;
endmodule
`default_nettype wire

/* File: gate_driver_aux_config_regs_bench.sv */
// Self-checking bench for the auxiliary gate drive register bank
`default_nettype none
`include "gdu_aux_defines.svh"
module gate_driver_aux_config_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import gdu_aux_pkg::*;

	logic        clk_i;
	logic        rst_n_i;
	bus_req_t    bus;
	logic  [7:0] rdata_o;
	logic        pwm_reload;
	logic        desat_err;
	logic  [2:0] phase_status;
	logic  [7:0] limit;
	logic  [1:0] duty;
	logic        boost_clk;
	phase_sel_t  act_sel;
	logic  [4:0] ratio;
	field_pair_t amp_off;
	field_pair_t desat_lvl;
	logic  [2:0] phase_log;
	logic        lock;
	int          error_cnt;
	int          comparisons;
	// Reference model: stored bytes, sticky lock, active select
	logic  [7:0] mdl [0:6];
	logic        m_lock;
	logic  [1:0] m_act;

	gate_driver_aux_config_regs dut_u (
		.clk_i                 (clk_i),
		.rst_n_i               (rst_n_i),
		.bus_i                 (bus),
		.rdata_o               (rdata_o),
		.pwm_reload_i          (pwm_reload),
		.desat_err_i           (desat_err),
		.phase_status_i        (phase_status),
		.boost_current_limit_o (limit),
		.boost_duty_o          (duty),
		.boost_clk_o           (boost_clk),
		.phase_sel_active_o    (act_sel),
		.divide_ratio_o        (ratio),
		.amp_offset_o          (amp_off),
		.desat_level_o         (desat_lvl),
		.phase_log_o           (phase_log),
		.write_lock_o          (lock)
	);

	// 200 MHz bus clock
	initial
	begin
		clk_i = 1'h0;
		forever #2.5 clk_i = ~clk_i;
	end

	task automatic print_verdict;
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Divide factor worked out from the code, independent of the decoder
	function automatic int fac(input int c);
		int t [0:15];
		t = '{16, 24, 32, 48, 64, 96, 100, 128, 192, 200, 256, 384, 400, 512, 768, 800};
		if (c < 6)
			return 4;
		if (c < 16)
			return (c / 2) * 2;
		return t[c - 16];
	endfunction

	// Keep writes inside the implemented bits so readback is predictable
	function automatic logic [7:0] mask(input int a);
		case (a)
			0: return 8'h7F;
			2: return 8'h03;
			3, 4: return 8'h77;
			default: return 8'hFF;
		endcase
	endfunction

	task automatic do_reset;
		@(posedge clk_i);
		rst_n_i <= 1'h0;
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'h1;
		foreach (mdl[i]) mdl[i] = 8'h00;
		m_lock = 1'h0;
		m_act = 2'h0;
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'h1;
		@(posedge clk_i);
		bus.wr <= 1'h0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		bus.addr <= a;
		bus.rd <= 1'h1;
		@(posedge clk_i);
		bus.rd <= 1'h0;
		#1;
		chk(16'(rdata_o), 16'(exp));
	endtask

	// Write through the model; locked registers and the log keep their value
	task automatic mwr(input int a, input logic [7:0] d);
		wr(a[3:0], d);
		if (a < 5 && a != 5 && !(m_lock && (a == 0 || a == 1 || a == 4)))
			mdl[a] = d;
	endtask

	task automatic reload;
		@(posedge clk_i);
		pwm_reload <= 1'h1;
		@(posedge clk_i);
		pwm_reload <= 1'h0;
		#1;
	endtask

	task automatic chk_outs;
		chk(16'(limit), 16'(mdl[1]));
		chk(16'(duty), 16'(mdl[0][1:0]));
		chk(16'(amp_off), 16'({mdl[3][6:4], mdl[3][2:0]}));
		chk(16'(desat_lvl), 16'({mdl[4][6:4], mdl[4][2:0]}));
		chk(16'(phase_log), 16'(mdl[5]));
		chk(16'(lock), 16'(m_lock));
		chk(16'(act_sel), 16'(m_act));
		chk(16'(ratio), (m_act == 2'h0) ? 16'h000C : 16'h0006);
	endtask

	// Cycles between the second and third rising edge of the boost clock
	task automatic period(output int n);
		int   edges;
		logic p;
		edges = 0;
		n = 0;
		p = boost_clk;
		for (int c = 0; c < 4000 && edges < 3; c++)
		begin
			@(posedge clk_i);
			#1;
			if (boost_clk === 1'h1 && p === 1'h0)
				edges++;
			if (edges == 2)
				n++;
			p = boost_clk;
		end
	endtask

	// Main sequence
	initial
	begin
		int          n;
		logic [7:0]  d;
		logic [2:0]  s;
		rst_n_i = 1'h0;
		bus = '0;
		pwm_reload = 1'h0;
		desat_err = 1'h0;
		phase_status = 3'h0;
		error_cnt = 0;
		comparisons = 0;
		void'($urandom(32'hC8F80EA5));
		do_reset;
		// Reset state and zero readback
		chk_outs;
		for (int a = 0; a < 7; a++) rd_chk(a[3:0], 8'h00);
		rd_chk(4'hF, 8'h00);
		// Every divider code, duty random
		for (int i = 0; i < 32; i++)
		begin
			d = 8'($urandom);
			mwr(`OFF_CLK_CTRL, {1'h0, i[4:0], d[1:0]});
			period(n);
			chk(16'(n), 16'(fac(i)));
			rd_chk(`OFF_CLK_CTRL, mdl[0]);
		end
		// Buffered select moves only at a reload after load okay
		for (int i = 1; i < 5; i++)
		begin
			mwr(`OFF_PHASE_SEL, 8'(i % 4));
			rd_chk(`OFF_PHASE_SEL, mdl[2]);
			reload;
			chk_outs;
			wr(`OFF_LOCK_CTRL, 8'h02);
			rd_chk(`OFF_LOCK_CTRL, 8'h02);
			reload;
			m_act = mdl[2][1:0];
			chk_outs;
		end
		// Random fields before and after the write lock is set
		for (int j = 0; j < 2; j++)
		begin
			for (int a = 0; a < 5; a++) mwr(a, 8'($urandom) & mask(a));
			chk_outs;
			for (int a = 0; a < 5; a++) rd_chk(a[3:0], mdl[a]);
			if (j == 0)
			begin
				wr(`OFF_LOCK_CTRL, 8'h01);
				m_lock = 1'h1;
			end
		end
		// Lock stays set when software tries to clear it
		wr(`OFF_LOCK_CTRL, 8'h00);
		rd_chk(`OFF_LOCK_CTRL, 8'h01);
		wr(4'hF, 8'hA5);
		// Phase log capture, ignored writes
		for (int i = 0; i < 4; i++)
		begin
			s = 3'($urandom);
			@(posedge clk_i);
			desat_err <= 1'h1;
			phase_status <= s;
			@(posedge clk_i);
			desat_err <= 1'h0;
			phase_status <= ~s;
			#1;
			mdl[5] = {5'h00, s};
			chk(16'(phase_log), 16'(s));
			mwr(`OFF_PHASE_LOG, {5'h00, ~s});
			chk_outs;
			rd_chk(`OFF_PHASE_LOG, mdl[5]);
		end
		// Reset in mid-run clears log, lock and selects
		do_reset;
		chk_outs;
		print_verdict;
	end

	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (60000) @(posedge clk_i);
		error_cnt++;
		print_verdict;
	end
endmodule
`default_nettype wire
